/* File: core/flash_seq_map.svh */
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// ****************************************
// software register offsets
// ****************************************
`define REG_CMD          4'h0
`define REG_ADDR         4'h4
`define REG_WDATA        4'h8
`define REG_STATUS       4'hC
`define REG_RDATA        4'h0
`define REG_RDATA_OFS    4'h0
`define REG_RWORD        4'h4

// ****************************************
// control register fields and reset values
// ****************************************
`define CMD_OP_LSB       0
`define STAT_BUSY        0
`define STAT_REFUSED     1
`define STAT_TIMEOUT     2
`define STAT_MODE        3
`define STAT_BYTE_LSB    8
`define FLASH_STAT_RST   8'h80

// ****************************************
// flash status byte bit positions
// ****************************************
`define ENGINE_READY_BIT          7
`define ERASE_SUSPENDED_BIT       6
`define ERASE_FAIL_BIT            5
`define PROGRAM_FAIL_BIT          4
`define SUPPLY_RANGE_ERROR_BIT    3
`define PROGRAM_SUSPENDED_BIT     2
`define LOCKED_SECTOR_ABORT_BIT   1

// ****************************************
// flash command codes
// ****************************************
`define CODE_PROGRAM     8'h40
`define CODE_ERASE       8'h20
`define CODE_CONFIRM     8'hD0
`define CODE_SUSPEND     8'hB0
`define CODE_STATUS      8'h70
`define CODE_READ_ARRAY  8'hFF
`define CODE_CLEAR       8'h50

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS    100
`define ERASE_SUSP_NS    15000
`define PROG_SUSP_NS     10000
`define ERASE_SUSP_CYC   (`ERASE_SUSP_NS / `CLK_PERIOD_NS)
`define PROG_SUSP_CYC    (`PROG_SUSP_NS / `CLK_PERIOD_NS)

`endif

/* File: core/flash_seq_pkg.sv */
package flash_seq_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_SETUP   = 3'h1,
        ST_STROBE  = 3'h3,
        ST_RELEASE = 3'h2,
        ST_GAP     = 3'h6
    } state_e;

    typedef enum logic [2:0] {
        OP_NONE    = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE   = 3'h2,
        OP_SUSPEND = 3'h3,
        OP_RESUME  = 3'h4,
        OP_READ    = 3'h5,
        OP_CLEAR   = 3'h6,
        OP_STATUS  = 3'h7
    } op_e;

endpackage

/* File: core/flash_seq_host.sv */
// Summary of operation
// [RULE1] program: setup 40, then data word
// [RULE2] each status read opens new chip-enable cycle
// [RULE3] poll until ready bit reads one
// [RULE4] FF returns device to array read
// [RULE5] program errors: supply, program, locked bits
// [RULE6] supply error blocks programs until cleared
// [RULE7] error bits cleared only by 50
// [RULE8] program suspend: B0, 70, poll, check bit2
// [RULE9] suspended program: FF reads, D0 resumes
// [RULE10] erase: 20 then D0 at sector
// [RULE11] bits 4 and 5 mean sequence error
// [RULE12] erase failure bit5, supply bit3
// [RULE13] locked sector erase aborts, sets bit1
// [RULE14] bits 1 or 3 block erases
// [RULE15] erase suspend: B0, 70, poll, bit6
// [RULE16] suspended erase: FF or 40, D0 resumes
// [RULE17] error bits accumulate over operations
// [RULE18] erase suspend done within 15 us
// [RULE19] program suspend done within 10 us
// [RULE20] status sits on low data byte
// [RULE21] status shown until read-array code
// [RULE22] cleared status bits read zero
`timescale 1ns/10ps
`include "flash_seq_map.svh"

module flash_seq_host #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // software register port
    input  wire logic [3:0]        bus_addr,
    input  wire logic [31:0]       bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic      [31:0]       bus_rdata,
    // flash pins
    output logic      [ADDR_W-1:0] flash_addr,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    output logic      [DATA_W-1:0] flash_dq_out,
    output logic                   flash_dq_oe,
    input  wire logic [DATA_W-1:0] flash_dq_in
);

    if (DATA_W < 8 || ADDR_W < 1 || ADDR_W > 32) begin : g_bad_width
        $error("flash_seq_host: unsupported width");
    end

    localparam logic [7:0] ERASE_LIM = 8'(`ERASE_SUSP_CYC);
    localparam logic [7:0] PROG_LIM  = 8'(`PROG_SUSP_CYC);

    // ****************************************
    // state
    // ****************************************
    flash_seq_pkg::state_e state;
    flash_seq_pkg::state_e next_state;
    flash_seq_pkg::op_e    op_q;
    logic [ADDR_W-1:0]     addr_reg;
    logic [DATA_W-1:0]     wdata_reg;
    logic [DATA_W-1:0]     rd_word;
    logic [7:0]            status_byte;
    logic [7:0]            poll_cnt;
    logic                  widx;
    logic                  next_widx;
    logic                  rd_q;
    logic                  next_rd;
    logic                  busy;
    logic                  refused;
    logic                  tmo;
    logic                  status_mode;
    logic                  last_erase;
    logic                  accept;
    logic                  refuse;
    flash_seq_pkg::op_e    cmd_op;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic two_writes(input flash_seq_pkg::op_e op);
        two_writes = (op == flash_seq_pkg::OP_PROGRAM) || (op == flash_seq_pkg::OP_ERASE) ||
                     (op == flash_seq_pkg::OP_SUSPEND);
    endfunction

    function automatic logic needs_read(input flash_seq_pkg::op_e op);
        needs_read = two_writes(op) || (op == flash_seq_pkg::OP_READ) ||
                     (op == flash_seq_pkg::OP_STATUS);
    endfunction

    function automatic logic [DATA_W-1:0] code_for(input flash_seq_pkg::op_e op,
                                                   input logic second,
                                                   input logic [DATA_W-1:0] wd);
        logic [7:0] c;
        c = `CODE_READ_ARRAY;
        case (op)
            flash_seq_pkg::OP_PROGRAM: c = `CODE_PROGRAM;
            flash_seq_pkg::OP_ERASE:   c = second ? `CODE_CONFIRM : `CODE_ERASE;
            flash_seq_pkg::OP_SUSPEND: c = second ? `CODE_STATUS : `CODE_SUSPEND; // RULE8 RULE15
            flash_seq_pkg::OP_RESUME:  c = `CODE_CONFIRM;                         // RULE9 RULE16
            flash_seq_pkg::OP_CLEAR:   c = `CODE_CLEAR;                           // RULE7
            flash_seq_pkg::OP_STATUS:  c = `CODE_STATUS;
            default:                   c = `CODE_READ_ARRAY;                      // RULE4
        endcase
        if (op == flash_seq_pkg::OP_PROGRAM && second) begin
            code_for = wd;
        end else begin
            code_for = DATA_W'(c);
        end
    endfunction

    // ****************************************
    // command acceptance
    // ****************************************
    assign cmd_op = flash_seq_pkg::op_e'(bus_wdata[`CMD_OP_LSB +: 3]);
    // a program under a supply error or an erase under a lock or supply error
    // would only be rejected by the device, so it is never sent
    assign refuse = busy || cmd_op == flash_seq_pkg::OP_NONE ||
                    (cmd_op == flash_seq_pkg::OP_PROGRAM &&
                     status_byte[`SUPPLY_RANGE_ERROR_BIT]) ||                        // RULE6
                    (cmd_op == flash_seq_pkg::OP_ERASE &&
                     (status_byte[`LOCKED_SECTOR_ABORT_BIT] ||
                      status_byte[`SUPPLY_RANGE_ERROR_BIT] ||
                      status_byte[`ERASE_SUSPENDED_BIT]));                          // RULE14
    assign accept = bus_wr && bus_addr == `REG_CMD && !refuse;

    // ****************************************
    // bus cycle sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_widx  = widx;
        next_rd    = rd_q;
        case (state)
            flash_seq_pkg::ST_IDLE: begin
                if (accept) begin
                    next_state = flash_seq_pkg::ST_SETUP;
                    next_widx  = 1'b0;
                    next_rd    = 1'b0;
                end
            end
            flash_seq_pkg::ST_SETUP:   next_state = flash_seq_pkg::ST_STROBE;
            flash_seq_pkg::ST_STROBE:  next_state = flash_seq_pkg::ST_RELEASE;
            flash_seq_pkg::ST_RELEASE: next_state = flash_seq_pkg::ST_GAP;
            flash_seq_pkg::ST_GAP: begin
                next_state = flash_seq_pkg::ST_IDLE;
                if (!rd_q && !widx && two_writes(op_q)) begin
                    next_state = flash_seq_pkg::ST_SETUP;                           // RULE1
                    next_widx  = 1'b1;
                end else if (!rd_q && needs_read(op_q)) begin
                    next_state = flash_seq_pkg::ST_SETUP;
                    next_rd    = 1'b1;
                end else if (rd_q && two_writes(op_q) && !tmo &&
                             !status_byte[`ENGINE_READY_BIT]) begin
                    next_state = flash_seq_pkg::ST_SETUP;                           // RULE3
                end
            end
            default: next_state = flash_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= flash_seq_pkg::ST_IDLE;
            widx  <= 1'b0;
            rd_q  <= 1'b0;
            op_q  <= flash_seq_pkg::OP_NONE;
        end else if (clk_en) begin
            state <= next_state;
            widx  <= next_widx;
            rd_q  <= next_rd;
            if (accept) begin
                op_q <= cmd_op;
            end
        end
    end

    // ****************************************
    // pins, registered; strobes and data decoded from the next state, address from addr_reg
    // ****************************************
    // the gap state lifts chip enable, so every poll is a fresh status sample
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_ce_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_dq_oe  <= 1'b0;
            flash_dq_out <= '0;
            flash_addr   <= '0;
        end else if (clk_en) begin
            flash_ce_n  <= next_state == flash_seq_pkg::ST_IDLE ||
                           next_state == flash_seq_pkg::ST_GAP;                     // RULE2
            flash_oe_n  <= !(next_state == flash_seq_pkg::ST_STROBE && next_rd);
            flash_we_n  <= !(next_state == flash_seq_pkg::ST_STROBE && !next_rd);
            flash_dq_oe <= !next_rd && (next_state == flash_seq_pkg::ST_SETUP ||
                                        next_state == flash_seq_pkg::ST_STROBE ||
                                        next_state == flash_seq_pkg::ST_RELEASE);
            flash_addr  <= addr_reg;                                                // RULE10
            if (next_state == flash_seq_pkg::ST_SETUP) begin
                flash_dq_out <= code_for(accept ? cmd_op : op_q, next_widx, wdata_reg);
            end
        end
    end

    // ****************************************
    // captured data and status copy
    // ****************************************
    // only the low byte is status; error bits are kept as read, so the
    // device's accumulation over a series of operations stays visible
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_byte <= `FLASH_STAT_RST;
            rd_word     <= '0;
        end else if (clk_en) begin
            if (state == flash_seq_pkg::ST_STROBE && rd_q) begin
                if (op_q == flash_seq_pkg::OP_READ) begin
                    rd_word <= flash_dq_in;
                end else begin
                    status_byte <= flash_dq_in[7:0];                                // RULE20
                end
            end else if (state == flash_seq_pkg::ST_GAP &&
                         op_q == flash_seq_pkg::OP_CLEAR) begin
                status_byte[5:1] <= 5'h0;                                           // RULE22
            end
        end
    end

    // ****************************************
    // control flags and suspend watchdog
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy        <= 1'b0;
            refused     <= 1'b0;
            tmo         <= 1'b0;
            status_mode <= 1'b0;
            last_erase  <= 1'b0;
            poll_cnt    <= 8'h0;
        end else if (clk_en) begin
            busy <= next_state != flash_seq_pkg::ST_IDLE;
            if (bus_wr && bus_addr == `REG_CMD) begin
                refused <= refuse;
            end
            if (accept) begin
                poll_cnt    <= 8'h0;
                tmo         <= 1'b0;
                status_mode <= cmd_op != flash_seq_pkg::OP_READ &&
                               (cmd_op != flash_seq_pkg::OP_CLEAR || status_mode);  // RULE21
                if (cmd_op == flash_seq_pkg::OP_ERASE) begin
                    last_erase <= 1'b1;
                end else if (cmd_op == flash_seq_pkg::OP_PROGRAM && !status_byte[6]) begin
                    last_erase <= 1'b0;
                end
            end else if (busy && op_q == flash_seq_pkg::OP_SUSPEND) begin
                if (poll_cnt != 8'hFF) begin
                    poll_cnt <= poll_cnt + 8'h1;
                end
                if (poll_cnt >= (last_erase ? ERASE_LIM : PROG_LIM)) begin
                    tmo <= 1'b1;                                                    // RULE18 RULE19
                end
            end
        end
    end

    // ****************************************
    // address and data registers, and register read port
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_reg  <= '0;
            wdata_reg <= '0;
            bus_rdata <= 32'h0;
        end else if (clk_en) begin
            if (bus_wr && bus_addr == `REG_ADDR && !busy) begin
                addr_reg <= bus_wdata[ADDR_W-1:0];
            end
            if (bus_wr && bus_addr == `REG_WDATA && !busy) begin
                wdata_reg <= bus_wdata[DATA_W-1:0];
            end
            bus_rdata <= 32'h0;
            if (bus_rd) begin
                case (bus_addr)
                    `REG_ADDR:   bus_rdata <= 32'(addr_reg);
                    `REG_WDATA:  bus_rdata <= 32'(wdata_reg);
                    `REG_STATUS: bus_rdata <= {16'h0, status_byte, 4'h0, status_mode,
                                               tmo, refused, busy};
                    default:     bus_rdata <= 32'(rd_word);
                endcase
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    prog_setup_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        (!flash_we_n && op_q == flash_seq_pkg::OP_PROGRAM && !widx)
        |-> flash_dq_out[7:0] == `CODE_PROGRAM)
        else $error("program setup code wrong");
    fresh_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
        $fell(flash_oe_n) |-> $past(flash_ce_n, 2) && !flash_ce_n)
        else $error("status read without new chip enable");
    poll_again_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
        (clk_en && state == flash_seq_pkg::ST_GAP && rd_q && two_writes(op_q) && !tmo &&
         !status_byte[7]) |=> state == flash_seq_pkg::ST_SETUP ##1 !flash_oe_n)
        else $error("busy engine not polled again");
    read_array_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
        (!flash_we_n && op_q == flash_seq_pkg::OP_READ) |-> flash_dq_out[7:0] == 8'hFF)
        else $error("read array code wrong");
    supply_block_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
        (clk_en && bus_wr && bus_addr == `REG_CMD && !busy && status_byte[3] &&
         bus_wdata[2:0] == 3'h1) |=> !busy && refused)
        else $error("program sent under supply error");
    clear_code_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        (!flash_we_n && op_q == flash_seq_pkg::OP_CLEAR) |-> flash_dq_out[7:0] == 8'h50)
        else $error("clear status code wrong");
    suspend_seq_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE8 RULE15
        (!flash_we_n && op_q == flash_seq_pkg::OP_SUSPEND)
        |-> flash_dq_out[7:0] == (widx ? 8'h70 : 8'hB0))
        else $error("suspend sequence wrong");
    erase_confirm_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
        (!flash_we_n && op_q == flash_seq_pkg::OP_ERASE && widx)
        |-> flash_dq_out[7:0] == 8'hD0 && flash_addr == addr_reg)
        else $error("erase confirm wrong");
    erase_block_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
        (clk_en && bus_wr && bus_addr == `REG_CMD && (status_byte[1] || status_byte[3]) &&
         bus_wdata[2:0] == 3'h2) |=> refused && $stable(op_q))
        else $error("erase sent under error");
    status_byte_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE20
        (clk_en && state == flash_seq_pkg::ST_STROBE && rd_q &&
         op_q != flash_seq_pkg::OP_READ) |=> status_byte == $past(flash_dq_in[7:0]))
        else $error("status not taken from low byte");

endmodule

/* File: bench/flash_dev_model.sv */
`timescale 1ns/10ps
module flash_dev_model (
    // flash pins
    input  wire logic [19:0] flash_addr,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    input  wire logic [15:0] flash_dq_out,
    output logic      [15:0] flash_dq_in,
    // fault knobs: locked, erase fail, program fail, supply bad
    input  wire logic [3:0]  fault,
    output int               wr_count
);
    logic [6:1]  flags = '0;
    logic [1:0]  pend = '0;
    logic        stat_mode = 1'b0;
    logic        erase_op = 1'b0;
    logic        junk = 1'b0;
    logic [7:0]  stat = 8'h80;
    logic [15:0] mem [16];
    int          cnt = 0;
    int          saved = 0;
    initial wr_count = 0;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // ****************************************
    // command decoder and write engine
    // ****************************************
    always @(posedge flash_we_n) begin
        if (flash_ce_n === 1'b0) begin
            wr_count = wr_count + 1;
            if (pend == 2'h1) begin
                if (!flags[3]) begin
                    if (fault[3]) flags[1] = 1'b1;
                    // a supply fault on a program shows as bits 3 and 4 together
                    else if (fault[0]) flags[4:3] = 2'b11;
                    else if (fault[1]) flags[4] = 1'b1;
                    else mem[flash_addr[3:0]] &= flash_dq_out;
                    cnt = 3;
                    erase_op = 1'b0;
                end
                pend = 2'h0;
            end else if (pend == 2'h2) begin
                if (flash_dq_out[7:0] != 8'hD0) flags[5:4] = 2'b11;
                else if (!(flags[1] | flags[3])) begin
                    if (fault[3]) flags[1] = 1'b1;
                    else if (fault[0]) flags[3] = 1'b1;
                    else if (fault[2]) flags[5] = 1'b1;
                    cnt = 3;
                    erase_op = 1'b1;
                end
                pend = 2'h0;
            end else begin
                stat_mode = 1'b1;
                case (flash_dq_out[7:0])
                    8'h40: pend = 2'h1;
                    8'h20: pend = 2'h2;
                    8'hFF: stat_mode = 1'b0;
                    // suspend flags are not errors and survive a clear
                    8'h50: {flags[5:3], flags[1]} = 4'h0;
                    // suspends at once, well inside both limits
                    8'hB0: if (cnt != 0) begin
                        saved = cnt;
                        cnt = 0;
                        flags[erase_op ? 6 : 2] = 1'b1;
                    end
                    8'hD0: if (flags[6] | flags[2]) begin
                        flags[6] = 1'b0;
                        flags[2] = 1'b0;
                        cnt = saved;
                    end
                    default: ;
                endcase
            end
        end
    end
    // status only refreshes on a new output-enable fall
    always @(negedge flash_oe_n) begin
        if (flash_ce_n === 1'b0) begin
            if (cnt != 0) cnt = cnt - 1;
            stat = {cnt == 0, flags, 1'b0};
        end
    end
    always @(posedge flash_oe_n) junk = ~junk;
    // released bus shows a changing pattern, never the last value
    always @* begin
        if (!flash_ce_n && !flash_oe_n)
            flash_dq_in = stat_mode ? {8'hA5 ^ {8{junk}}, stat} : mem[flash_addr[3:0]];
        else
            flash_dq_in = junk ? 16'hA5C3 : 16'h5A3C;
    end
endmodule

/* File: bench/flash_seq_host_test.sv */
`timescale 1ns/10ps
`include "flash_seq_map.svh"
module flash_seq_host_test;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic [3:0]  bus_addr = '0;
    logic [31:0] bus_wdata = '0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic [19:0] flash_addr;
    logic        flash_ce_n;
    logic        flash_oe_n;
    logic        flash_we_n;
    logic [15:0] flash_dq_out;
    logic        flash_dq_oe;
    logic [15:0] flash_dq_in;
    logic [3:0]  fault = '0;
    int          wr_count;
    int          fail_count = 0;
    int          checked = 0;
    always #50 clk = ~clk;
    flash_seq_host u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in));
    flash_dev_model u_flash (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out),
        .flash_dq_in(flash_dq_in), .fault(fault), .wr_count(wr_count));
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    // issue a command and poll busy, bounded
    task automatic run(input logic [2:0] op, input logic [7:0] exp, input int nwr);
        logic [31:0] s;
        int          n;
        n = wr_count;
        wr(`REG_CMD, {29'h0, op});
        for (int i = 0; i < 100; i++) begin
            rd(`REG_STATUS, s);
            if (s[0] === 1'b0) break;
        end
        chk("busy", 1'b0, s[0]);
        chk("refused", nwr == 0, s[1]);
        chk("status byte", exp, s[15:8]);
        chk("flash writes", nwr, wr_count - n);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        logic [31:0] s;
        chk("pins", 4'hE, {flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe});
        rd(`REG_STATUS, s);
        chk("reset status", 8'h80, s[15:8]);
    endtask
    // with the enable low nothing may reach the flash or the read port
    task automatic t_freeze;
        logic [31:0] s;
        int          n;
        n = wr_count;
        @(posedge clk);
        clk_en <= 1'b0;
        wr(`REG_CMD, 32'h7);
        rd(`REG_STATUS, s);
        chk("frozen writes", 0, wr_count - n);
        chk("frozen rdata", 32'h0, s);
        @(posedge clk);
        clk_en <= 1'b1;
    endtask
    task automatic t_program;
        logic [31:0] s;
        wr(`REG_ADDR, 32'h3);
        wr(`REG_WDATA, 32'h1234);
        rd(`REG_ADDR, s);
        chk("addr reg", 32'h3, s);
        rd(`REG_WDATA, s);
        chk("wdata reg", 32'h1234, s);
        run(flash_seq_pkg::OP_PROGRAM, 8'h80, 2);
        rd(`REG_STATUS, s);
        chk("status mode", 1'b1, s[3]);
        run(flash_seq_pkg::OP_READ, 8'h80, 1);
        rd(`REG_RDATA, s);
        chk("array word", 32'h1234, s);
        rd(4'h2, s);
        chk("unmapped", 32'h1234, s);
        rd(`REG_STATUS, s);
        chk("array mode", 1'b0, s[3]);
    endtask
    task automatic t_prog_fail;
        fault = 4'h2;
        run(flash_seq_pkg::OP_PROGRAM, 8'h90, 2);
        fault = 4'h0;
        run(flash_seq_pkg::OP_PROGRAM, 8'h90, 2);
        run(flash_seq_pkg::OP_STATUS, 8'h90, 1);
        run(flash_seq_pkg::OP_CLEAR, 8'h80, 1);
    endtask
    task automatic t_supply;
        fault = 4'h1;
        run(flash_seq_pkg::OP_PROGRAM, 8'h98, 2);
        fault = 4'h0;
        run(flash_seq_pkg::OP_PROGRAM, 8'h98, 0);
        run(flash_seq_pkg::OP_ERASE, 8'h98, 0);
        run(flash_seq_pkg::OP_CLEAR, 8'h80, 1);
        run(flash_seq_pkg::OP_PROGRAM, 8'h80, 2);
    endtask
    task automatic t_erase;
        fault = 4'h8;
        run(flash_seq_pkg::OP_ERASE, 8'h82, 2);
        run(flash_seq_pkg::OP_ERASE, 8'h82, 0);
        run(flash_seq_pkg::OP_CLEAR, 8'h80, 1);
        fault = 4'h4;
        run(flash_seq_pkg::OP_ERASE, 8'hA0, 2);
        fault = 4'h1;
        run(flash_seq_pkg::OP_ERASE, 8'hA8, 2);
        run(flash_seq_pkg::OP_CLEAR, 8'h80, 1);
        fault = 4'h0;
        run(flash_seq_pkg::OP_ERASE, 8'h80, 2);
    endtask
    task automatic t_suspend;
        logic [31:0] s;
        run(flash_seq_pkg::OP_SUSPEND, 8'h80, 2);
        rd(`REG_STATUS, s);
        chk("suspend timeout", 1'b0, s[2]);
        run(flash_seq_pkg::OP_RESUME, 8'h80, 1);
        run(flash_seq_pkg::OP_PROGRAM, 8'h80, 2);
        run(flash_seq_pkg::OP_SUSPEND, 8'h80, 2);
        run(flash_seq_pkg::OP_RESUME, 8'h80, 1);
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_freeze;
        t_program;
        t_prog_fail;
        t_supply;
        t_erase;
        t_suspend;
        give_verdict;
    end
    // the whole run needs well under 10000 cycles
    initial begin
        #2000000;
        fail_count++;
        give_verdict;
    end
endmodule
